// *** rtl/tpgpio_regs.svh ***
// register offsets, masks and reset values of the three-port gpio bank
//----------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------
// Summary of operation
// - pull-up-disable bit forces every pull-up off
// - io offsets 0x00-0x3F, data space adds 0x20
// - port b latch rw at 0x18, reset zero
// - port b direction rw at 0x17, reset zero
// - port b pin levels read-only at 0x16
// - port c latch bits 6:0 at 0x15
// - port c direction bits 6:0 at 0x14
// - port c pin levels bits 6:0 at 0x13
// - port d latch rw at 0x12, reset zero
// - port d direction rw at 0x11, reset zero
// - port d pin levels read-only at 0x10
`ifndef TPGPIO_REGS_SVH
`define TPGPIO_REGS_SVH

`define TPGPIO_IO_LAST 6'h3F
`define TPGPIO_DS_OFFSET 8'h20
`define TPGPIO_DS_EXT_START 8'h60

`define TPGPIO_D_LEVELS_OFF 6'h10
`define TPGPIO_D_DIR_OFF 6'h11
`define TPGPIO_D_LATCH_OFF 6'h12
`define TPGPIO_C_LEVELS_OFF 6'h13
`define TPGPIO_C_DIR_OFF 6'h14
`define TPGPIO_C_LATCH_OFF 6'h15
`define TPGPIO_B_LEVELS_OFF 6'h16
`define TPGPIO_B_DIR_OFF 6'h17
`define TPGPIO_B_LATCH_OFF 6'h18

`define TPGPIO_LATCH_RST 8'h00
`define TPGPIO_DIR_RST 8'h00
`define TPGPIO_READ_NONE 8'h00
`define TPGPIO_MASK_FULL 8'hFF
`define TPGPIO_MASK_C 8'h7F

`endif

// *** rtl/tpgpio_pkg.sv ***
// types shared by the three-port gpio bank
package tpgpio_pkg;
	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_IO,
		SRC_DATA
	} tpgpio_src_type;
endpackage

// *** rtl/tpgpio_bank.sv ***
// register bank and pin control for gpio ports b, c and d
`timescale 1ns/100ps
`include "tpgpio_regs.svh"

module tpgpio_bank (
	input wire logic clock_i, // cpu clock, 10 MHz
	input wire logic rstn_i, // asynchronous reset, active low
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic [5:0] io_addr_i, // io-space offset
	input wire logic io_wr_i, // io-space write strobe
	input wire logic io_rd_i, // io-space read strobe
	input wire logic [7:0] ds_addr_i, // data-space address
	input wire logic ds_wr_i, // data-space write strobe
	input wire logic ds_rd_i, // data-space read strobe
	input wire logic [7:0] wdata_i, // write data
	output logic [7:0] rdata_o, // read data, one cycle after the strobe
	input wire logic global_pullup_off_i, // global pull-up disable
	input wire logic [7:0] port_b_pins_i, // port b pin levels
	output logic [7:0] port_b_out_o, // port b output values
	output logic [7:0] port_b_oe_o, // port b output enables
	output logic [7:0] port_b_pullup_o, // port b pull-up enables
	input wire logic [6:0] port_c_pins_i, // port c pin levels
	output logic [6:0] port_c_out_o, // port c output values
	output logic [6:0] port_c_oe_o, // port c output enables
	output logic [6:0] port_c_pullup_o, // port c pull-up enables
	input wire logic [7:0] port_d_pins_i, // port d pin levels
	output logic [7:0] port_d_out_o, // port d output values
	output logic [7:0] port_d_oe_o, // port d output enables
	output logic [7:0] port_d_pullup_o // port d pull-up enables
);

	//----------------------------------------------------------------
	// per-port constants, index 0 = b, 1 = c, 2 = d
	//----------------------------------------------------------------
	localparam logic [5:0] LVL_OFF [3] = '{`TPGPIO_B_LEVELS_OFF, `TPGPIO_C_LEVELS_OFF,
		`TPGPIO_D_LEVELS_OFF};
	localparam logic [5:0] DIR_OFF [3] = '{`TPGPIO_B_DIR_OFF, `TPGPIO_C_DIR_OFF,
		`TPGPIO_D_DIR_OFF};
	localparam logic [5:0] LAT_OFF [3] = '{`TPGPIO_B_LATCH_OFF, `TPGPIO_C_LATCH_OFF,
		`TPGPIO_D_LATCH_OFF};
	localparam logic [7:0] MASK [3] = '{`TPGPIO_MASK_FULL, `TPGPIO_MASK_C, `TPGPIO_MASK_FULL};

	logic [7:0] pins_in [3];
	logic [7:0] latch_ff [3];
	logic [7:0] dir_ff [3];
	logic [7:0] sync1_ff [3];
	logic [7:0] sync2_ff [3];
	logic [7:0] pullup_ff [3];
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic ds_hit;
	logic acc_wr;
	logic acc_rd;
	logic [5:0] acc_off;
	tpgpio_pkg::tpgpio_src_type acc_src;

	assign pins_in[0] = port_b_pins_i;
	assign pins_in[1] = {1'b0, port_c_pins_i};
	assign pins_in[2] = port_d_pins_i;

	//----------------------------------------------------------------
	// access decode
	//----------------------------------------------------------------
	// the extended region from 0x60 belongs to other blocks, so data-space
	// accesses there are ignored here
	assign ds_hit = (ds_addr_i >= `TPGPIO_DS_OFFSET) && (ds_addr_i < `TPGPIO_DS_EXT_START);

	// io strobes win when both spaces strobe in the same cycle
	always_comb begin
		if (io_wr_i || io_rd_i) begin
			acc_src = tpgpio_pkg::SRC_IO;
		end else if ((ds_wr_i || ds_rd_i) && ds_hit) begin
			acc_src = tpgpio_pkg::SRC_DATA;
		end else begin
			acc_src = tpgpio_pkg::SRC_NONE;
		end
	end

	always_comb begin
		unique case (acc_src)
			tpgpio_pkg::SRC_IO: begin
				acc_off = io_addr_i & `TPGPIO_IO_LAST;
				acc_wr = io_wr_i;
				acc_rd = io_rd_i;
			end
			tpgpio_pkg::SRC_DATA: begin
				acc_off = 6'(ds_addr_i - `TPGPIO_DS_OFFSET);
				acc_wr = ds_wr_i;
				acc_rd = ds_rd_i;
			end
			default: begin
				acc_off = 6'h00;
				acc_wr = 1'b0;
				acc_rd = 1'b0;
			end
		endcase
	end

	//----------------------------------------------------------------
	// per-port registers and pin control
	//----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_port
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					latch_ff[p] <= `TPGPIO_LATCH_RST;
				end else if (ce_i && acc_wr && acc_off == LAT_OFF[p]) begin
					latch_ff[p] <= wdata_i & MASK[p];
				end
			end

			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					dir_ff[p] <= `TPGPIO_DIR_RST;
				end else if (ce_i && acc_wr && acc_off == DIR_OFF[p]) begin
					dir_ff[p] <= wdata_i & MASK[p];
				end
			end

			// first stage feeds only the second stage
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					sync1_ff[p] <= 8'h00;
					sync2_ff[p] <= 8'h00;
				end else if (ce_i) begin
					sync1_ff[p] <= pins_in[p] & MASK[p];
					sync2_ff[p] <= sync1_ff[p];
				end
			end

			// registered so the pad control is glitch free; lags the latch and direction registers by one cycle
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					pullup_ff[p] <= 8'h00;
				end else if (ce_i) begin
					pullup_ff[p] <= ~dir_ff[p] & latch_ff[p] & {8{~global_pullup_off_i}};
				end
			end

			// both stages must have loaded out of reset, so the first of the two
			// enabled edges has to see reset already released
			sequence s_two_enabled;
				rstn_i && ce_i ##1 ce_i;
			endsequence

			a_latch_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && acc_wr && acc_off == LAT_OFF[p] |=> latch_ff[p] == ($past(wdata_i) & MASK[p]))
				else $error("latch did not take written value");
			a_dir_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && acc_wr && acc_off == DIR_OFF[p] |=> dir_ff[p] == ($past(wdata_i) & MASK[p]))
				else $error("direction did not take written value");
			a_pullup_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && global_pullup_off_i |=> pullup_ff[p] == 8'h00)
				else $error("pull-up on while globally disabled");
			a_pullup_input: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && !global_pullup_off_i |=>
				pullup_ff[p] == (~$past(dir_ff[p]) & $past(latch_ff[p])))
				else $error("pull-up does not follow direction and latch");
			a_sync_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
				s_two_enabled |=> sync2_ff[p] == ($past(pins_in[p], 2) & MASK[p]))
				else $error("pin level not two cycles behind the pin");
			a_level_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && acc_rd && acc_off == LVL_OFF[p] |=> rdata_o == $past(sync2_ff[p]))
				else $error("level read returned wrong value");
			a_ext_ignored: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && ds_wr_i && !io_wr_i && !io_rd_i && ds_addr_i >= `TPGPIO_DS_EXT_START
				|=> $stable(latch_ff[p]) && $stable(dir_ff[p]))
				else $error("extended region write changed a port register");
			a_low_ignored: assert property (@(posedge clock_i) disable iff (!rstn_i)
				ce_i && ds_wr_i && !io_wr_i && !io_rd_i && ds_addr_i < `TPGPIO_DS_OFFSET
				|=> $stable(latch_ff[p]) && $stable(dir_ff[p]))
				else $error("data-space write below the window changed a port register");
		end
	endgenerate

	//----------------------------------------------------------------
	// read path
	//----------------------------------------------------------------
	always_comb begin
		nxt_rdata = `TPGPIO_READ_NONE;
		for (int i = 0; i < 3; i++) begin
			if (acc_off == LVL_OFF[i]) begin
				nxt_rdata = sync2_ff[i];
			end else if (acc_off == DIR_OFF[i]) begin
				nxt_rdata = dir_ff[i];
			end else if (acc_off == LAT_OFF[i]) begin
				nxt_rdata = latch_ff[i];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_ff <= `TPGPIO_READ_NONE;
		end else if (ce_i && acc_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	a_ds_alias: assert property (@(posedge clock_i) disable iff (!rstn_i)
		ce_i && ds_rd_i && !io_rd_i && !io_wr_i
		&& ds_addr_i == ({2'b00, `TPGPIO_D_DIR_OFF} + `TPGPIO_DS_OFFSET)
		|=> rdata_o == $past(dir_ff[2]))
		else $error("data-space alias read wrong register");
	a_unmapped_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
		ce_i && acc_rd && (acc_off < `TPGPIO_D_LEVELS_OFF || acc_off > `TPGPIO_B_LATCH_OFF)
		|=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_c_top_bit: assert property (@(posedge clock_i) disable iff (!rstn_i)
		latch_ff[1][7] == 1'b0 && dir_ff[1][7] == 1'b0 && sync2_ff[1][7] == 1'b0)
		else $error("port c bit 7 implemented");

	//----------------------------------------------------------------
	// outputs
	//----------------------------------------------------------------
	assign rdata_o = rdata_ff;
	assign port_b_out_o = latch_ff[0];
	assign port_b_oe_o = dir_ff[0];
	assign port_b_pullup_o = pullup_ff[0];
	assign port_c_out_o = latch_ff[1][6:0];
	assign port_c_oe_o = dir_ff[1][6:0];
	assign port_c_pullup_o = pullup_ff[1][6:0];
	assign port_d_out_o = latch_ff[2];
	assign port_d_oe_o = dir_ff[2];
	assign port_d_pullup_o = pullup_ff[2];

endmodule // tpgpio_bank

// *** sim/tpgpio_pin_model.sv ***
// pin-side model of the circuitry attached to one gpio port
`timescale 1ns/100ps

module tpgpio_pin_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] out_i, // port output values
	input wire logic [W-1:0] oe_i, // port output enables
	input wire logic [W-1:0] ext_i, // level driven by outside circuitry
	output logic [W-1:0] level_o // resolved pin level
);
	// outside drivers are stronger than a pull-up, so the pull-up never shows here
	assign level_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // tpgpio_pin_model

// *** sim/tb_top.sv ***
// self-checking bench for the three-port gpio register bank
`timescale 1ns/100ps

module tb_top;
	logic clock_i = 1'h0, rstn_i = 1'h0, ce_i = 1'h1, io_wr_i = 1'h0, io_rd_i = 1'h0;
	logic ds_wr_i = 1'h0, ds_rd_i = 1'h0, pu_off = 1'h0, chk = 1'h0, pend = 1'h0;
	logic [5:0] io_addr_i = 6'h00;
	logic [7:0] ds_addr_i = 8'h00, wdata_i = 8'h00, rdata_o, e;
	logic [7:0] pn [3], po [3], oe [3], pu [3], ext [3], lat [3], dir [3];
	logic [7:0] q [$];
	int n_errors = 0, cmp_count = 0;

	tpgpio_bank DUT (.clock_i, .rstn_i, .ce_i, .io_addr_i, .io_wr_i, .io_rd_i, .ds_addr_i,
		.ds_wr_i, .ds_rd_i, .wdata_i, .rdata_o, .global_pullup_off_i(pu_off),
		.port_b_pins_i(pn[0]), .port_b_out_o(po[0]), .port_b_oe_o(oe[0]), .port_b_pullup_o(pu[0]),
		.port_c_pins_i(pn[1][6:0]), .port_c_out_o(po[1][6:0]), .port_c_oe_o(oe[1][6:0]),
		.port_c_pullup_o(pu[1][6:0]),
		.port_d_pins_i(pn[2]), .port_d_out_o(po[2]), .port_d_oe_o(oe[2]), .port_d_pullup_o(pu[2]));
	tpgpio_pin_model #(.W(8)) PB (.out_i(po[0]), .oe_i(oe[0]), .ext_i(ext[0]), .level_o(pn[0]));
	tpgpio_pin_model #(.W(7)) PC (.out_i(po[1][6:0]), .oe_i(oe[1][6:0]), .ext_i(ext[1][6:0]),
		.level_o(pn[1][6:0]));
	tpgpio_pin_model #(.W(8)) PD (.out_i(po[2]), .oe_i(oe[2]), .ext_i(ext[2]), .level_o(pn[2]));

	initial begin
		forever #50 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] m(input int p);
		return p == 1 ? 8'h7F : 8'hFF;
	endfunction
	function automatic logic [7:0] base(input int p);
		return 8'h16 - 8'(3 * p);
	endfunction
	function automatic logic [7:0] pinv(input int p);
		return (dir[p] & lat[p] | ~dir[p] & ext[p]) & m(p);
	endfunction

	task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one strobe pulse; a read also notes its expected byte for the monitor
	task automatic acc(input logic ds, input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		io_addr_i <= a[5:0];
		ds_addr_i <= a;
		wdata_i <= d;
		{io_wr_i, io_rd_i, ds_wr_i, ds_rd_i} <= {wr & ~ds, ~wr & ~ds, wr & ds, ~wr & ds};
		chk <= ~wr;
		if (!wr)
			q.push_back(d);
		@(posedge clock_i);
		{io_wr_i, io_rd_i, ds_wr_i, ds_rd_i, chk} <= 5'h00;
	endtask

	always @(posedge clock_i) begin
		if (pend)
			cmp(rdata_o, q.pop_front());
		pend <= chk;
	end

	task automatic ports(input int p);
		e = ~dir[p] & lat[p] & {8{~pu_off}};
		cmp(po[p] & m(p), lat[p]);
		cmp(oe[p] & m(p), dir[p]);
		cmp(pu[p] & m(p), e);
	endtask

	task automatic rstchk;
		for (int p = 0; p < 3; p++) begin
			lat[p] = 8'h00;
			dir[p] = 8'h00;
			acc(1'h0, 1'h0, base(p) + 8'h02, 8'h00);
			acc(1'h0, 1'h0, base(p) + 8'h01, 8'h00);
			acc(1'h0, 1'h0, base(p), pinv(p));
			ports(p);
		end
	endtask

	task automatic conclude;
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		void'($urandom(75));
		for (int p = 0; p < 3; p++)
			ext[p] = 8'($urandom) & m(p);
		repeat (5) @(posedge clock_i);
		rstn_i <= 1'h1;
		repeat (3) @(posedge clock_i);
		rstchk();
		repeat (4) for (int p = 0; p < 3; p++) begin
			lat[p] = 8'($urandom) & m(p);
			dir[p] = 8'($urandom) & m(p);
			pu_off <= 1'($urandom);
			acc(1'h0, 1'h1, base(p) + 8'h02, lat[p] | ~m(p));
			acc(1'h1, 1'h1, base(p) + 8'h21, dir[p] | ~m(p));
			acc(1'h0, 1'h1, base(p), ~ext[p]);
			acc(1'h1, 1'h0, base(p) + 8'h22, lat[p]);
			acc(1'h0, 1'h0, base(p) + 8'h01, dir[p]);
			acc(1'h0, 1'h0, base(p), pinv(p));
			ports(p);
		end
		// data-space accesses outside 0x20..0x5F must not reach the bank
		acc(1'h1, 1'h1, 8'h72, ~lat[2]);
		acc(1'h1, 1'h1, 8'h12, ~lat[2]);
		acc(1'h0, 1'h0, 8'h12, lat[2]);
		acc(1'h0, 1'h0, 8'h20, 8'h00);
		acc(1'h1, 1'h0, 8'h40, 8'h00);
		acc(1'h0, 1'h0, 8'h05, 8'h00);
		acc(1'h1, 1'h0, 8'h31, dir[2]);
		// both spaces strobe together: the io access is taken, the data one lost
		@(posedge clock_i);
		{io_addr_i, ds_addr_i, wdata_i} <= {6'h18, 8'h37, ~lat[0]};
		{io_wr_i, ds_wr_i} <= 2'h3;
		@(posedge clock_i);
		{io_wr_i, ds_wr_i} <= 2'h0;
		lat[0] = ~lat[0];
		acc(1'h0, 1'h0, 8'h18, lat[0]);
		acc(1'h0, 1'h0, 8'h17, dir[0]);
		@(posedge clock_i);
		ce_i <= 1'h0;
		acc(1'h0, 1'h1, 8'h18, ~lat[0]);
		ce_i <= 1'h1;
		acc(1'h0, 1'h0, 8'h18, lat[0]);
		e = pinv(0);
		@(posedge clock_i);
		ext[0] <= ~ext[0];
		acc(1'h0, 1'h0, 8'h16, e);
		acc(1'h0, 1'h0, 8'h16, pinv(0));
		@(posedge clock_i);
		rstn_i <= 1'h0;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'h1;
		rstchk();
		repeat (2) @(posedge clock_i);
		conclude();
	end

	initial begin
		#(100 * 5000);
		n_errors++;
		conclude();
	end
endmodule // tb_top
